// File: bmf_ctrl.v
// control logic of the bus matching synchronous fifo
`timescale 1ns/10ps
`include "bmf_map.vh"
module bmf_ctrl #(
    parameter AW = 11,
    parameter DEPTH = 2048
) (
    input wire i_clock,
    input wire i_srst,
    input wire i_side_a_clock,
    input wire i_side_b_clock,
    input wire i_side_a_gate,
    input wire i_side_b_gate,
    input wire i_side_a_select_n,
    input wire i_side_b_select_n,
    input wire i_side_a_dir,
    input wire i_side_b_dir,
    input wire i_side_a_mailbox_sel,
    input wire i_side_b_mailbox_sel,
    input wire i_reset_one_n,
    input wire i_reset_two_n,
    input wire i_partial_reset_or_replay_n,
    input wire i_replay_mode_sel,
    input wire i_width_narrow_sel,
    input wire i_width_choice,
    input wire i_endian_or_timing,
    input wire i_offset_sel_0,
    input wire i_offset_sel_1,
    input wire i_offset_sel_2,
    input wire [35:0] i_side_a_data,
    input wire [35:0] i_side_b_data,
    output reg [35:0] o_side_a_data,
    output reg o_side_a_data_oe,
    output reg [35:0] o_side_b_data,
    output reg o_side_b_data_oe,
    output reg o_full_or_input_ready,
    output reg o_empty_or_output_ready,
    output reg o_almost_full_n,
    output reg o_almost_empty_n,
    output reg o_mailbox1_full_n,
    output reg o_mailbox2_full_n
);
    localparam [31:0] OFS_8 = `BMF_OFS_8;
    localparam [31:0] OFS_16 = `BMF_OFS_16;
    localparam [31:0] OFS_64 = `BMF_OFS_64;
    localparam [31:0] OFS_256 = `BMF_OFS_256;
    localparam [31:0] OFS_1024 = `BMF_OFS_1024;
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
    localparam [AW:0] SER_BITS = {AW[AW-1:0], 1'b0};
    localparam DW = `BMF_DATA_BITS;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    wire [`BMF_CTRL_BITS-1:0] ctrl_sync;
    wire [DW-1:0] a_din;
    wire [DW-1:0] b_din;
    wire a_clk, b_clk, a_gate, b_gate, a_sel_n, b_sel_n, a_dir, b_dir;
    wire a_mbx, b_mbx, rs1_n, rs2_n, prs_act, replay_mode_sel, narrow, wchoice;
    wire endian_timing, fs0, fs1, fs2;

    bmf_sync #(.WIDTH(`BMF_CTRL_BITS)) u_ctrl_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_pin({i_side_a_clock, i_side_b_clock, i_side_a_gate, i_side_b_gate,
            i_side_a_select_n, i_side_b_select_n, i_side_a_dir, i_side_b_dir,
            i_side_a_mailbox_sel, i_side_b_mailbox_sel, i_reset_one_n,
            i_reset_two_n, ~i_partial_reset_or_replay_n, i_replay_mode_sel,
            i_width_narrow_sel, i_width_choice, i_endian_or_timing,
            i_offset_sel_0}),
        .o_level(ctrl_sync)
    );

    bmf_sync #(.WIDTH(2 + 2 * DW)) u_data_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_pin({i_offset_sel_1, i_offset_sel_2, i_side_a_data, i_side_b_data}),
        .o_level({fs1, fs2, a_din, b_din})
    );

    assign {a_clk, b_clk, a_gate, b_gate, a_sel_n, b_sel_n, a_dir, b_dir, a_mbx,
        b_mbx, rs1_n, rs2_n, prs_act, replay_mode_sel, narrow, wchoice, endian_timing,
        fs0} = ctrl_sync;
    wire prs_n = ~prs_act; // inverted so a cleared synchroniser reads idle

    // -----------------------------------------------------------------
    // edge detection on synchronised levels
    // -----------------------------------------------------------------
    reg a_clk_d, b_clk_d, rs1_d, prs_d;

    always @(posedge i_clock) begin
        if (i_srst) begin
            a_clk_d <= 1'b0;
            b_clk_d <= 1'b0;
            rs1_d <= 1'b0;
            prs_d <= 1'b1;
        end else begin
            a_clk_d <= a_clk;
            b_clk_d <= b_clk;
            rs1_d <= rs1_n;
            prs_d <= prs_n;
        end
    end

    wire in_reset = ~rs1_n | ~rs2_n;
    wire part_reset = ~prs_n & ~replay_mode_sel;
    wire a_edge = a_clk & ~a_clk_d & a_gate & ~a_sel_n & ~in_reset;
    wire b_edge = b_clk & ~b_clk_d & b_gate & ~b_sel_n & ~in_reset;
    wire a_wr = a_edge & a_dir;
    wire a_rd = a_edge & ~a_dir;
    wire b_wr = b_edge & ~b_dir;
    wire b_rd = b_edge & b_dir;
    wire rs1_rise = rs1_n & ~rs1_d;
    wire replay_done = replay_mode_sel & prs_n & ~prs_d;

    // -----------------------------------------------------------------
    // configuration latched at end of reset_one, except timing mode, which follows the pin unlatched
    // -----------------------------------------------------------------
    reg [1:0] method;
    reg [1:0] bus_width;
    reg big_endian;

    function [AW-1:0] preset_of;
        input [2:0] code;
        begin
            case (code)
                `BMF_SEL_P8: preset_of = OFS_8[AW-1:0];
                `BMF_SEL_P16: preset_of = OFS_16[AW-1:0];
                `BMF_SEL_P64: preset_of = OFS_64[AW-1:0];
                `BMF_SEL_P256: preset_of = OFS_256[AW-1:0];
                default: preset_of = OFS_1024[AW-1:0];
            endcase
        end
    endfunction

    function [1:0] parts_of;
        input [1:0] width;
        begin
            case (width)
                `BMF_W_WORD: parts_of = `BMF_PARTS_WORD;
                `BMF_W_BYTE: parts_of = `BMF_PARTS_BYTE;
                default: parts_of = `BMF_PARTS_LONG;
            endcase
        end
    endfunction

    function [DW-1:0] width_mask;
        input [1:0] width;
        begin
            case (width)
                `BMF_W_WORD: width_mask = {{(DW - `BMF_WORD_BITS){1'b0}},
                    {`BMF_WORD_BITS{1'b1}}};
                `BMF_W_BYTE: width_mask = {{(DW - `BMF_BYTE_BITS){1'b0}},
                    {`BMF_BYTE_BITS{1'b1}}};
                default: width_mask = {DW{1'b1}};
            endcase
        end
    endfunction

    always @(posedge i_clock) begin
        if (i_srst) begin
            method <= `BMF_MTH_PRESET;
            bus_width <= `BMF_W_LONG;
            big_endian <= 1'b0;
        end else if (rs1_rise) begin
            case ({fs2, fs1, fs0})
                `BMF_SEL_PAR: method <= `BMF_MTH_PAR;
                `BMF_SEL_SER: method <= `BMF_MTH_SER;
                default: method <= `BMF_MTH_PRESET;
            endcase
            if (!narrow) begin
                bus_width <= `BMF_W_LONG;
            end else if (wchoice) begin
                bus_width <= `BMF_W_BYTE;
            end else begin
                bus_width <= `BMF_W_WORD;
            end
            big_endian <= endian_timing;
        end
    end

    wire std_timing = endian_timing;

    // -----------------------------------------------------------------
    // flag offset registers
    // -----------------------------------------------------------------
    reg [AW-1:0] ofs_empty;
    reg [AW-1:0] ofs_full;
    reg [AW:0] load_cnt;
    reg loaded;

    always @(posedge i_clock) begin
        if (i_srst) begin
            ofs_empty <= OFS_8[AW-1:0];
            ofs_full <= OFS_8[AW-1:0];
            load_cnt <= {(AW + 1){1'b0}};
            loaded <= 1'b0;
        end else if (rs1_rise) begin
            ofs_empty <= preset_of({fs2, fs1, fs0});
            ofs_full <= preset_of({fs2, fs1, fs0});
            load_cnt <= {(AW + 1){1'b0}};
            loaded <= 1'b0;
        end else if (method == `BMF_MTH_PRESET) begin
            loaded <= ~in_reset;
        end else if (!loaded && method == `BMF_MTH_SER) begin
            if (a_clk & ~a_clk_d & ~fs1 & ~in_reset) begin
                {ofs_full, ofs_empty} <= {ofs_full[AW-2:0], ofs_empty, fs0};
                load_cnt <= load_cnt + 1'b1;
                loaded <= (load_cnt == SER_BITS - 1'b1);
            end
        end else if (!loaded && a_wr) begin
            if (load_cnt == {(AW + 1){1'b0}}) begin
                ofs_empty <= a_din[AW-1:0];
            end else begin
                ofs_full <= a_din[AW-1:0];
                loaded <= 1'b1;
            end
            load_cnt <= load_cnt + 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // fifo memory and pointers
    // -----------------------------------------------------------------
    reg [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg [1:0] part;

    wire full = (count == FULL_COUNT);
    wire empty = (count == {(AW + 1){1'b0}});
    wire fifo_wr = a_wr & ~a_mbx & loaded & ~full;
    wire fifo_rd = b_rd & ~b_mbx & ~empty;
    wire last_part = (part == parts_of(bus_width));
    wire pop = fifo_rd & last_part;
    wire [1:0] lane = big_endian ? parts_of(bus_width) - part : part;
    wire [DW-1:0] head = mem[rd_ptr];
    reg [DW-1:0] next_b_word;

    always @* begin
        case (bus_width)
            `BMF_W_WORD: next_b_word = lane[0] ?
                {{(DW - `BMF_WORD_BITS){1'b0}}, head[DW-1:`BMF_WORD_BITS]} :
                {{(DW - `BMF_WORD_BITS){1'b0}}, head[`BMF_WORD_BITS-1:0]};
            `BMF_W_BYTE: next_b_word = {{(DW - `BMF_BYTE_BITS){1'b0}},
                head[lane * `BMF_BYTE_BITS +: `BMF_BYTE_BITS]};
            default: next_b_word = head;
        endcase
    end

    always @(posedge i_clock) begin
        if (fifo_wr) begin
            mem[wr_ptr] <= a_din;
        end
    end

    always @(posedge i_clock) begin
        if (i_srst || (~rs1_n & ~rs2_n) || part_reset) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW + 1){1'b0}};
            part <= 2'h0;
        end else if (replay_done) begin
            rd_ptr <= {AW{1'b0}};
            count <= full ? count : {1'b0, wr_ptr};
            part <= 2'h0;
        end else begin
            if (fifo_wr) begin
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (fifo_rd) begin
                part <= last_part ? 2'h0 : part + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (fifo_wr && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !fifo_wr) begin
                count <= count - 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // mailboxes
    // -----------------------------------------------------------------
    reg [DW-1:0] mail1;
    reg [DW-1:0] mail2;

    always @(posedge i_clock) begin
        if (i_srst) begin
            mail1 <= {DW{1'b0}};
            mail2 <= {DW{1'b0}};
            o_mailbox1_full_n <= 1'b1;
            o_mailbox2_full_n <= 1'b1;
        end else begin
            if (~rs1_n || part_reset) begin
                o_mailbox1_full_n <= 1'b1;
            end else if (a_wr && a_mbx && o_mailbox1_full_n) begin
                mail1 <= a_din & width_mask(bus_width);
                o_mailbox1_full_n <= 1'b0;
            end else if (b_rd && b_mbx) begin
                o_mailbox1_full_n <= 1'b1;
            end
            if (~rs2_n || part_reset) begin
                o_mailbox2_full_n <= 1'b1;
            end else if (b_wr && b_mbx && o_mailbox2_full_n) begin
                mail2 <= b_din & width_mask(bus_width);
                o_mailbox2_full_n <= 1'b0;
            end else if (a_rd && a_mbx) begin
                o_mailbox2_full_n <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // data outputs and enables
    // -----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_side_a_data <= {DW{1'b0}};
            o_side_b_data <= {DW{1'b0}};
            o_side_a_data_oe <= 1'b0;
            o_side_b_data_oe <= 1'b0;
        end else begin
            o_side_a_data_oe <= ~a_sel_n & ~a_dir;
            o_side_b_data_oe <= ~b_sel_n & b_dir;
            if (a_rd && a_mbx) begin
                o_side_a_data <= mail2;
            end
            if ((~rs1_n & ~rs2_n) || part_reset) begin
                o_side_b_data <= {DW{1'b0}};
            end else if (b_rd && b_mbx) begin
                o_side_b_data <= mail1;
            end else if (fifo_rd) begin
                o_side_b_data <= next_b_word;
            end
        end
    end

    // -----------------------------------------------------------------
    // status flags
    // -----------------------------------------------------------------
    wire [AW:0] space = FULL_COUNT - count;

    always @(posedge i_clock) begin
        if (i_srst) begin
            o_full_or_input_ready <= 1'b0;
            o_empty_or_output_ready <= 1'b0;
            o_almost_full_n <= 1'b1;
            o_almost_empty_n <= 1'b0;
        end else begin
            // standard: low when full; fall-through: low when space exists
            if (std_timing) begin
                o_full_or_input_ready <= ~full & loaded & ~in_reset;
                o_empty_or_output_ready <= ~empty & ~in_reset;
            end else begin
                o_full_or_input_ready <= full | ~loaded | in_reset;
                o_empty_or_output_ready <= empty | in_reset;
            end
            o_almost_full_n <= space > {1'b0, ofs_full};
            o_almost_empty_n <= count > {1'b0, ofs_empty};
        end
    end
endmodule // bmf_ctrl

// File: bmf_ctrl_assertions.sv
// pin-level checks on the fifo control block
`timescale 1ns/10ps
module bmf_ctrl_chk (
    input wire i_clock,
    input wire i_srst,
    input wire i_side_a_gate,
    input wire i_side_b_gate,
    input wire i_side_a_select_n,
    input wire i_side_a_dir,
    input wire i_side_b_dir,
    input wire i_reset_one_n,
    input wire i_reset_two_n,
    input wire i_partial_reset_or_replay_n,
    input wire i_replay_mode_sel,
    input wire [35:0] o_side_b_data,
    input wire o_side_a_data_oe,
    input wire o_side_b_data_oe,
    input wire o_mailbox1_full_n,
    input wire o_mailbox2_full_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    AST_A_DIR: assert property (i_side_a_dir [*4] |=> !o_side_a_data_oe)
        else $error("side A drives during write");
    AST_A_OE: assert property ((!i_side_a_select_n && !i_side_a_dir) [*4] |=> o_side_a_data_oe)
        else $error("side A not driving during read");
    AST_A_SEL: assert property (i_side_a_select_n [*4] |=> !o_side_a_data_oe)
        else $error("side A drives while deselected");
    AST_B_DIR: assert property (!i_side_b_dir [*4] |=> !o_side_b_data_oe)
        else $error("side B drives during write");
    AST_MB1_RST: assert property (!i_reset_one_n [*4] |=> o_mailbox1_full_n)
        else $error("mailbox one flag low in reset");
    AST_MB2_RST: assert property (!i_reset_two_n [*4] |=> o_mailbox2_full_n)
        else $error("mailbox two flag low in reset");
    AST_B_ZERO: assert property ((!i_reset_one_n && !i_reset_two_n) [*4]
        |=> o_side_b_data == 36'h0) else $error("side B output not cleared");
    AST_PART: assert property ((!i_partial_reset_or_replay_n && !i_replay_mode_sel) [*4]
        |=> (o_side_b_data == 36'h0) && o_mailbox1_full_n && o_mailbox2_full_n)
        else $error("partial reset left state");
    AST_GATE_A: assert property (!i_side_a_gate [*8] |=> !$fell(o_mailbox1_full_n))
        else $error("mailbox one set without gate");
    AST_GATE_B: assert property (!i_side_b_gate [*8] |=> !$fell(o_mailbox2_full_n))
        else $error("mailbox two set without gate");
endmodule // bmf_ctrl_chk

// File: bmf_map.vh
// constants for the bus matching fifo control block
`ifndef BMF_MAP_VH
`define BMF_MAP_VH

// -----------------------------------------------------------------
// offset programming methods, from {sel_2, sel_1, sel_0}
// -----------------------------------------------------------------
`define BMF_SEL_P8 3'h0
`define BMF_SEL_P16 3'h1
`define BMF_SEL_P64 3'h2
`define BMF_SEL_P256 3'h3
`define BMF_SEL_PAR 3'h4
`define BMF_SEL_SER 3'h5
`define BMF_SEL_P1024 3'h6

`define BMF_MTH_PRESET 2'h0
`define BMF_MTH_PAR 2'h1
`define BMF_MTH_SER 2'h2

`define BMF_OFS_8 32'h0000_0008
`define BMF_OFS_16 32'h0000_0010
`define BMF_OFS_64 32'h0000_0040
`define BMF_OFS_256 32'h0000_0100
`define BMF_OFS_1024 32'h0000_0400

// -----------------------------------------------------------------
// side B bus widths
// -----------------------------------------------------------------
`define BMF_W_LONG 2'h0
`define BMF_W_WORD 2'h1
`define BMF_W_BYTE 2'h2

`define BMF_PARTS_LONG 2'h0
`define BMF_PARTS_WORD 2'h1
`define BMF_PARTS_BYTE 2'h3
`define BMF_WORD_BITS 18
`define BMF_BYTE_BITS 9
`define BMF_DATA_BITS 36
`define BMF_CTRL_BITS 18

`endif

// File: bmf_side_model.sv
// free-running port clocks of the two hosts
`timescale 1ns/10ps
module bmf_side_model #(
    parameter HALF_A = 400,
    parameter HALF_B = 500
) (
    output logic o_side_a_clock,
    output logic o_side_b_clock
);
    // periods of 8 and 10 system clocks, edges only on falling system clock edges
    initial o_side_a_clock = 1'b0;
    initial o_side_b_clock = 1'b0;
    always #(HALF_A) o_side_a_clock = ~o_side_a_clock;
    always #(HALF_B) o_side_b_clock = ~o_side_b_clock;
endmodule // bmf_side_model

// File: bmf_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module bmf_sync #(
    parameter WIDTH = 1
) (
    input wire i_clock,
    input wire i_srst,
    input wire [WIDTH-1:0] i_pin,
    output reg [WIDTH-1:0] o_level
);
    reg [WIDTH-1:0] meta;

    always @(posedge i_clock) begin
        if (i_srst) begin
            meta <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
        end else begin
            meta <= i_pin;
            o_level <= meta;
        end
    end
endmodule // bmf_sync

// File: bmf_tb.sv
// self-checking bench for the fifo control block
`timescale 1ns/10ps
module tb;
    logic i_clock = 1'b0, i_srst = 1'b1, i_side_a_clock, i_side_b_clock;
    logic i_side_a_gate = 1'b0, i_side_b_gate = 1'b0;
    logic i_side_a_select_n = 1'b1, i_side_b_select_n = 1'b1;
    logic i_side_a_dir = 1'b1, i_side_b_dir = 1'b0;
    logic i_side_a_mailbox_sel = 1'b0, i_side_b_mailbox_sel = 1'b0;
    logic i_reset_one_n = 1'b0, i_reset_two_n = 1'b0;
    logic i_partial_reset_or_replay_n = 1'b1, i_replay_mode_sel = 1'b0;
    logic i_width_narrow_sel = 1'b0, i_width_choice = 1'b0, i_endian_or_timing = 1'b1;
    logic i_offset_sel_0 = 1'b0, i_offset_sel_1 = 1'b0, i_offset_sel_2 = 1'b0;
    logic [35:0] i_side_a_data = 36'h0, i_side_b_data = 36'h0, o_side_a_data, o_side_b_data;
    logic o_side_a_data_oe, o_side_b_data_oe, o_full_or_input_ready, o_empty_or_output_ready;
    logic o_almost_full_n, o_almost_empty_n, o_mailbox1_full_n, o_mailbox2_full_n;
    logic [35:0] tab_in [4] = '{36'hf_ffff_ffff, 36'h0_0000_0001, 36'h8_0000_0000, 36'h5_a5a5_a5a5};
    logic [35:0] tab_out [4] = '{36'hf_ffff_ffff, 36'h0_0000_0001, 36'h8_0000_0000, 36'h5_a5a5_a5a5};
    logic [35:0] w = 36'h1_2345_6789;
    int err_total = 0;
    int compares = 0;
    int k;

    always #50 i_clock = ~i_clock;

    bmf_side_model bmf_side_model_inst (.o_side_a_clock(i_side_a_clock),
        .o_side_b_clock(i_side_b_clock));
    bmf_ctrl #(.AW(4), .DEPTH(16)) bmf_ctrl_inst (
        .i_clock, .i_srst, .i_side_a_clock, .i_side_b_clock, .i_side_a_gate, .i_side_b_gate,
        .i_side_a_select_n, .i_side_b_select_n, .i_side_a_dir, .i_side_b_dir,
        .i_side_a_mailbox_sel, .i_side_b_mailbox_sel, .i_reset_one_n, .i_reset_two_n,
        .i_partial_reset_or_replay_n, .i_replay_mode_sel, .i_width_narrow_sel, .i_width_choice,
        .i_endian_or_timing, .i_offset_sel_0, .i_offset_sel_1, .i_offset_sel_2, .i_side_a_data,
        .i_side_b_data, .o_side_a_data, .o_side_a_data_oe, .o_side_b_data, .o_side_b_data_oe,
        .o_full_or_input_ready, .o_empty_or_output_ready, .o_almost_full_n, .o_almost_empty_n,
        .o_mailbox1_full_n, .o_mailbox2_full_n);

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk_data(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t data %h want %h", $time, got, exp);
        end
    endtask

    task chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t flag %b want %b", $time, got, exp);
        end
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    task wait_clk(input bit s, input logic v);
        int n;
        for (n = 0; n < 40 && (s ? i_side_b_clock : i_side_a_clock) !== v; n++)
            @(posedge i_clock);
        if (n == 40) begin
            err_total++;
            $display("BAD t=%0t side clock stuck", $time);
            final_report();
        end
    endtask

    // one transfer on one side clock rise; s high picks side B
    task xfer(input bit s, input logic g, input logic dir, input logic mb, input logic [35:0] d);
        wait_clk(s, 1'b1);
        wait_clk(s, 1'b0);
        #5;
        if (s) begin
            {i_side_b_gate, i_side_b_select_n, i_side_b_dir, i_side_b_mailbox_sel} = {g, 1'b0, dir, mb};
            i_side_b_data = d;
        end else begin
            {i_side_a_gate, i_side_a_select_n, i_side_a_dir, i_side_a_mailbox_sel} = {g, 1'b0, dir, mb};
            i_side_a_data = d;
        end
        wait_clk(s, 1'b1);
        repeat (6) @(posedge i_clock);
        #5;
        {i_side_a_gate, i_side_b_gate, i_side_a_select_n, i_side_b_select_n} = 4'h3;
        {i_side_a_dir, i_side_b_dir} = 2'h2;
    endtask

    task reset_pins();
        @(posedge i_clock);
        #5;
        {i_reset_one_n, i_reset_two_n} = 2'h0;
        repeat (50) @(posedge i_clock);
        chk_data(o_side_b_data, 36'h0);
        chk_flag(o_mailbox1_full_n & o_mailbox2_full_n, 1'b1);
        #5;
        {i_reset_one_n, i_reset_two_n} = 2'h3;
        repeat (10) @(posedge i_clock);
        #5;
    endtask

    task part_pulse();
        @(posedge i_clock);
        #5;
        i_partial_reset_or_replay_n = 1'b0;
        repeat (6) @(posedge i_clock);
        #5;
        i_partial_reset_or_replay_n = 1'b1;
        repeat (10) @(posedge i_clock);
        #5;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge i_clock);
        #5;
        i_srst = 1'b0;
        reset_pins();
        done("reset");
        for (k = 0; k < 4; k++)
            xfer(1'b0, 1'b1, 1'b1, 1'b0, tab_in[k]);
        for (k = 0; k < 4; k++) begin
            xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
            chk_data(o_side_b_data, tab_out[k]);
        end
        xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        chk_data(o_side_b_data, tab_out[3]);
        done("table");
        xfer(1'b0, 1'b0, 1'b1, 1'b1, 36'h1_1111_1111);
        chk_flag(o_mailbox1_full_n, 1'b1);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h1_2345_6789);
        chk_flag(o_mailbox1_full_n, 1'b0);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h9_8765_4321);
        xfer(1'b1, 1'b1, 1'b1, 1'b1, 36'h0);
        chk_data(o_side_b_data, 36'h1_2345_6789);
        chk_flag(o_mailbox1_full_n, 1'b1);
        xfer(1'b1, 1'b0, 1'b0, 1'b1, 36'h2_2222_2222);
        chk_flag(o_mailbox2_full_n, 1'b1);
        xfer(1'b1, 1'b1, 1'b0, 1'b1, 36'h3_c3c3_c3c3);
        chk_flag(o_mailbox2_full_n, 1'b0);
        xfer(1'b1, 1'b1, 1'b0, 1'b1, 36'h4_4444_4444);
        xfer(1'b0, 1'b1, 1'b0, 1'b1, 36'h0);
        chk_data(o_side_a_data, 36'h3_c3c3_c3c3);
        chk_flag(o_mailbox2_full_n, 1'b1);
        done("mailbox");
        for (k = 0; k < 16; k++)
            xfer(1'b0, 1'b1, 1'b1, 1'b0, {4'ha, k[31:0]});
        chk_flag(o_full_or_input_ready, 1'b0);
        chk_flag(o_almost_full_n, 1'b0);
        chk_flag(o_almost_empty_n, 1'b1);
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'hb_0000_0000);
        for (k = 0; k < 16; k++)
            xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        chk_data(o_side_b_data, {4'ha, 32'd15});
        chk_flag(o_empty_or_output_ready, 1'b0);
        chk_flag(o_almost_full_n, 1'b1);
        chk_flag(o_almost_empty_n, 1'b0);
        done("full");
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h7_7777_7777);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h6_6666_6666);
        part_pulse();
        chk_data(o_side_b_data, 36'h0);
        chk_flag(o_empty_or_output_ready & o_mailbox1_full_n, 1'b0);
        chk_flag(o_mailbox1_full_n, 1'b1);
        i_replay_mode_sel = 1'b1;
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'hc_0000_0001);
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'hd_0000_0002);
        xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        chk_data(o_side_b_data, 36'hc_0000_0001);
        part_pulse();
        xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        chk_data(o_side_b_data, 36'hc_0000_0001);
        xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        chk_data(o_side_b_data, 36'hd_0000_0002);
        i_replay_mode_sel = 1'b0;
        done("replay");
        {i_width_narrow_sel, i_width_choice, i_endian_or_timing} = 3'h6;
        {i_offset_sel_2, i_offset_sel_1, i_offset_sel_0} = 3'h5;
        reset_pins();
        i_endian_or_timing = 1'b1;
        repeat (80) @(posedge i_clock);
        xfer(1'b0, 1'b1, 1'b1, 1'b0, w);
        chk_flag(o_almost_full_n, 1'b0);
        for (k = 0; k < 4; k++) begin
            xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
            chk_data(o_side_b_data, {27'h0, w[9*k +: 9]});
        end
        done("byte");
        {i_width_narrow_sel, i_width_choice, i_endian_or_timing} = 3'h5;
        {i_offset_sel_2, i_offset_sel_1, i_offset_sel_0} = 3'h4;
        reset_pins();
        i_endian_or_timing = 1'b0;
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
        xfer(1'b0, 1'b1, 1'b1, 1'b0, w);
        chk_flag(o_almost_empty_n, 1'b1);
        chk_flag(o_full_or_input_ready | o_empty_or_output_ready, 1'b0);
        for (k = 0; k < 2; k++) begin
            xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
            chk_data(o_side_b_data, {18'h0, w[18 - 18 * k +: 18]});
        end
        done("word");
        final_report();
    end
endmodule // tb

bind bmf_ctrl bmf_ctrl_chk bmf_ctrl_chk_inst (
    .i_clock, .i_srst, .i_side_a_gate, .i_side_b_gate, .i_side_a_select_n, .i_side_a_dir,
    .i_side_b_dir, .i_reset_one_n, .i_reset_two_n, .i_partial_reset_or_replay_n,
    .i_replay_mode_sel, .o_side_b_data, .o_side_a_data_oe, .o_side_b_data_oe,
    .o_mailbox1_full_n, .o_mailbox2_full_n);
